// *** rtl/adcc_pkg.sv ***
package adcc_pkg;
  // result frame and configuration word
  localparam int RESULT_BITS   = 24;
  localparam int CFG_BITS      = 16;
  localparam int CNT_W         = 5;
  // configuration field positions within the received word
  localparam int CFG_CH_LSB    = 0;
  localparam int CFG_CH_W      = 4;
  localparam int CFG_SGL_BIT   = 4;
  localparam int CFG_TEMP_BIT  = 5;
  localparam int CFG_REJ_LSB   = 6;
  localparam int CFG_REJ_W     = 2;
  localparam int CFG_SPD_BIT   = 8;
  localparam int CFG_GAIN_LSB  = 9;
  localparam int CFG_GAIN_W    = 3;
  // power-on configuration: ch0 minus ch1, 50/60 rejection, 1x, gain 1
  localparam logic [3:0] RST_CH    = 4'h0;
  localparam logic       RST_SGL   = 1'b0;
  localparam logic       RST_TEMP  = 1'b0;
  localparam logic [1:0] RST_REJ   = 2'h0;
  localparam logic       RST_SPD   = 1'b0;
  localparam logic [2:0] RST_GAIN  = 3'h0;
  // result codes outside the input range
  localparam logic [23:0] CODE_OVER  = 24'hC0_0000;
  localparam logic [23:0] CODE_UNDER = 24'h3F_FFFF;
  // timing
  localparam int CLK_HZ         = 100_000_000;
  localparam int OSC_HZ         = 307_200;
  localparam int OSC_HALF_CYC   = CLK_HZ / (2 * OSC_HZ);
  localparam int ISCK_HZ        = 38_400;
  localparam int ISCK_HALF_CYC  = CLK_HZ / (2 * ISCK_HZ);
  // edges after reset until the sck pin level is through the synchroniser
  localparam logic [1:0] BOOT_CYC = 2'h3;
  localparam int CONV_OSC_TICKS = 41036;

  typedef enum logic [3:0] {
    ST_CONV  = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_IDLE  = 4'b1000
  } adcc_state_t;
endpackage

// *** rtl/adcc_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module adcc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [W-1:0] rst_val_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta <= rst_val_i;
      q_o  <= rst_val_i;
    end else if (ce_i) begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// *** rtl/adcc_ctrl.sv ***
`timescale 1ns/1ps
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int CONV_TICKS = CONV_OSC_TICKS,
  parameter int OSC_HALF   = OSC_HALF_CYC,
  parameter int ISCK_HALF  = ISCK_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // serial pins
  input  wire logic        cs_n_i,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        conv_clock_pin_i,
  // analog core side
  input  wire logic [15:0] core_result_i,
  input  wire logic        core_over_i,
  input  wire logic        core_under_i,
  output logic             conv_start_o,
  output logic             converting_o,
  output logic             sleep_o,
  output logic [3:0]       pos_sel_o,
  output logic [3:0]       neg_sel_o,
  output logic             neg_is_shared_o,
  output logic             temp_sel_o,
  output logic [1:0]       rej_mode_o,
  output logic             speed_2x_o,
  output logic [2:0]       gain_o,
  output logic             sck_internal_o
);
  adcc_state_t state;
  adcc_state_t next_state;
  logic [3:0]  pins;
  logic        cs_n_s, sck_s, sdi_s, fpin_s;
  logic        cs_n_d, sck_d, fpin_d;
  logic        sck_int;
  logic [15:0] isck_cnt;
  logic [15:0] osc_cnt;
  logic        osc_tick_int;
  logic [31:0] conv_cnt;
  logic [CNT_W-1:0] bit_cnt;
  logic        seen_rise;
  logic [RESULT_BITS-1:0] shreg;
  logic [CFG_BITS-1:0]    cfg_sh;
  logic [CFG_BITS-1:0]    cfg;
  logic        ext_osc;
  logic [1:0]  boot;

  adcc_sync #(.W(4)) u_sync (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .d_i       ({cs_n_i, sck_i, sdi_i, conv_clock_pin_i}),
    .rst_val_i (4'b1000),
    .q_o       (pins)
  );
  assign cs_n_s = pins[3];
  assign sck_s  = pins[2];
  assign sdi_s  = pins[1];
  assign fpin_s = pins[0];

  wire cs_fall = cs_n_d & ~cs_n_s;
  wire cs_rise = ~cs_n_d & cs_n_s;
  wire xfer    = (state == ST_XFER);
  wire ext_rise = ~sck_d & sck_s;
  wire ext_fall = sck_d & ~sck_s;
  wire int_tog  = (isck_cnt == 16'(ISCK_HALF - 1));
  wire int_rise = int_tog & ~sck_int;
  wire int_fall = int_tog & sck_int;
  wire s_rise = xfer & ~cs_n_s & (sck_internal_o ? int_rise : ext_rise);
  wire s_fall = xfer & ~cs_n_s & (sck_internal_o ? int_fall : ext_fall);
  wire last_bit = (bit_cnt == CNT_W'(RESULT_BITS - 1));
  // conversion tick: internal oscillator or rising edges of the conv clock pin
  wire ext_tick = ~fpin_d & fpin_s;
  wire conv_tick = ext_osc ? ext_tick : osc_tick_int;
  wire conv_done = (state == ST_CONV) & conv_tick &
                   (conv_cnt == 32'(CONV_TICKS - 1));

  // result word: status bits, then sign-extended data or range codes
  wire [23:0] result_word =
    core_over_i  ? CODE_OVER  :
    core_under_i ? CODE_UNDER :
    {2'b00, ~core_result_i[15], core_result_i[15],
     core_result_i, 4'h0};

  always_comb begin
    next_state = state;
    case (state)
      ST_CONV:  if (conv_done) next_state = ST_SLEEP;
      ST_SLEEP: if (cs_fall) next_state = ST_XFER;
      ST_XFER: begin
        if (cs_rise && !seen_rise)
          next_state = ST_SLEEP;
        else if (cs_rise)
          next_state = ST_CONV;
        else if (s_fall && last_bit && seen_rise)
          next_state = ST_CONV;
      end
      ST_IDLE:  next_state = ST_CONV;
      default:  next_state = ST_CONV;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state  <= ST_IDLE;
      cs_n_d <= 1'b1;
      sck_d  <= 1'b0;
      fpin_d <= 1'b0;
    end else if (ce_i) begin
      state  <= next_state;
      cs_n_d <= cs_n_s;
      sck_d  <= sck_s;
      fpin_d <= fpin_s;
    end
  end

  // sck mode caught after reset release and on each cs fall;
  // keeps looking until the pin level has passed the synchroniser
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sck_internal_o <= 1'b0;
      boot           <= BOOT_CYC;
    end else if (ce_i) begin
      if (boot != 2'h0)
        boot <= boot - 2'h1;
      if (boot != 2'h0 || cs_fall)
        sck_internal_o <= sck_s;
    end
  end

  // oscillator source chosen by whether the conv clock pin toggles
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ext_osc <= 1'b0;
    end else if (ce_i) begin
      if (ext_tick)
        ext_osc <= 1'b1;
      else if (state == ST_SLEEP && !fpin_s)
        ext_osc <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      osc_cnt      <= '0;
      osc_tick_int <= 1'b0;
    end else if (ce_i) begin
      osc_tick_int <= (osc_cnt == 16'(2 * OSC_HALF - 1));
      if (osc_cnt == 16'(2 * OSC_HALF - 1))
        osc_cnt <= '0;
      else
        osc_cnt <= osc_cnt + 16'd1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      conv_cnt <= '0;
    end else if (ce_i) begin
      if (state != ST_CONV)
        conv_cnt <= '0;
      else if (conv_tick)
        conv_cnt <= conv_cnt + 32'd1;
    end
  end

  // internal serial clock, runs only during a transfer with cs low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      isck_cnt <= '0;
      sck_int  <= 1'b0;
    end else if (ce_i) begin
      if (!xfer || cs_n_s || !sck_internal_o) begin
        isck_cnt <= '0;
        sck_int  <= 1'b0;
      end else if (int_tog) begin
        isck_cnt <= '0;
        sck_int  <= ~sck_int;
      end else begin
        isck_cnt <= isck_cnt + 16'd1;
      end
    end
  end

  // shift out on falling sck, sample sdi on rising sck
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      shreg     <= '0;
      cfg_sh    <= '0;
      bit_cnt   <= '0;
      seen_rise <= 1'b0;
    end else if (ce_i) begin
      if (conv_done) begin
        shreg <= result_word;
      end else if (state == ST_SLEEP && cs_fall) begin
        bit_cnt   <= '0;
        seen_rise <= 1'b0;
      end else if (s_rise) begin
        seen_rise <= 1'b1;
        if (bit_cnt < CNT_W'(CFG_BITS))
          cfg_sh <= {cfg_sh[CFG_BITS-2:0], sdi_s};
      end else if (s_fall && seen_rise) begin
        shreg   <= {shreg[RESULT_BITS-2:0], 1'b0};
        bit_cnt <= bit_cnt + CNT_W'(1);
      end
    end
  end

  // configuration takes effect for the conversion that follows
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cfg <= {4'h0, RST_GAIN, RST_SPD, RST_REJ, RST_TEMP,
              RST_SGL, RST_CH};
    end else if (ce_i) begin
      if (xfer && next_state == ST_CONV &&
          bit_cnt >= CNT_W'(CFG_BITS))
        cfg <= cfg_sh;
    end
  end

  // mux decode: channel field and single-ended bit
  wire [3:0] ch = cfg[CFG_CH_LSB +: CFG_CH_W];
  wire       sgl = cfg[CFG_SGL_BIT];
  assign pos_sel_o       = ch;
  assign neg_sel_o       = sgl ? 4'h0 : (ch ^ 4'h1);
  assign neg_is_shared_o = sgl;
  assign temp_sel_o      = cfg[CFG_TEMP_BIT];
  assign rej_mode_o      = cfg[CFG_REJ_LSB +: CFG_REJ_W];
  assign speed_2x_o      = cfg[CFG_SPD_BIT];
  assign gain_o          = cfg[CFG_GAIN_LSB +: CFG_GAIN_W];
  // core restarts from scratch each conversion, nothing discarded
  assign conv_start_o = (state != ST_CONV) &&
                        (next_state == ST_CONV);
  assign converting_o = (state == ST_CONV);
  assign sleep_o      = (state == ST_SLEEP) & cs_n_s;

  // pins: sdo enable follows cs; sck enable also needs internal sck and a transfer
  assign sdo_oe_o = ~cs_n_s;
  assign sdo_o    = xfer ? shreg[RESULT_BITS-1]
                         : (state == ST_CONV);
  assign sck_o    = sck_int;
  assign sck_oe_o = sck_internal_o & xfer & ~cs_n_s;
endmodule

// *** bench/adcc_ctrl_chk.sv ***
`timescale 1ns/1ps
module adcc_ctrl_chk #(
  parameter int CONV_TICKS = 20,
  parameter int OSC_HALF   = 2,
  parameter int ISCK_HALF  = 2
) (
  // clock, reset, chip select
  input wire logic       clk_i, resetn_i, cs_n_i,
  // serial pin drivers
  input wire logic       sck_oe_o, sdo_o, sdo_oe_o, sck_internal_o,
  // conversion state
  input wire logic       conv_start_o, converting_o, sleep_o,
  // configuration
  input wire logic [3:0] pos_sel_o, neg_sel_o,
  input wire logic       neg_is_shared_o, temp_sel_o, speed_2x_o,
  input wire logic [1:0] rej_mode_o,
  input wire logic [2:0] gain_o
);
  // an external conversion clock may stretch a conversion several times
  localparam int LO = CONV_TICKS * 2 * OSC_HALF - 10;
  localparam int HI = CONV_TICKS * 20 * OSC_HALF;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_hiz; cs_n_i[*4] |-> !sdo_oe_o; endproperty
  a_hiz: assert property (p_hiz) else $error("sdo on, cs high");
  property p_wake; !cs_n_i[*4] |-> sdo_oe_o; endproperty
  a_wake: assert property (p_wake) else $error("sdo off, cs low");
  property p_busy; converting_o |-> sdo_o; endproperty
  a_busy: assert property (p_busy) else $error("busy flag low");
  property p_done; cs_n_i[*4] ##0 $fell(converting_o) |-> !sdo_o; endproperty
  a_done: assert property (p_done) else $error("done flag high");
  property p_sleep; sleep_o && cs_n_i |=> sleep_o; endproperty
  a_sleep: assert property (p_sleep) else $error("left sleep");
  property p_len; $rose(converting_o) |-> ##[LO:HI] $fell(converting_o);
  endproperty
  a_len: assert property (p_len) else $error("conv length");
  property p_start; conv_start_o |=> converting_o && !conv_start_o; endproperty
  a_start: assert property (p_start) else $error("start pulse");
  property p_oe; sck_oe_o |-> sck_internal_o; endproperty
  a_oe: assert property (p_oe) else $error("sck driven ext");
  property p_sckz; cs_n_i[*4] |-> !sck_oe_o; endproperty
  a_sckz: assert property (p_sckz) else $error("sck on, cs high");
  property p_mode; cs_n_i[*6] |=> $stable(sck_internal_o); endproperty
  a_mode: assert property (p_mode) else $error("mode changed");
  property p_cfg; cs_n_i[*6] |=> $stable({pos_sel_o, neg_sel_o,
    neg_is_shared_o, temp_sel_o, rej_mode_o, speed_2x_o, gain_o});
  endproperty
  a_cfg: assert property (p_cfg) else $error("config changed");
  property p_pair; !neg_is_shared_o |-> neg_sel_o == (pos_sel_o ^ 4'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("pair wrong");
endmodule
bind adcc_ctrl adcc_ctrl_chk #(
  .CONV_TICKS(CONV_TICKS), .OSC_HALF(OSC_HALF), .ISCK_HALF(ISCK_HALF)
) u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_oe_o(sck_oe_o),
  .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sck_internal_o(sck_internal_o),
  .conv_start_o(conv_start_o), .converting_o(converting_o),
  .sleep_o(sleep_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
  .neg_is_shared_o(neg_is_shared_o), .temp_sel_o(temp_sel_o),
  .speed_2x_o(speed_2x_o), .rej_mode_o(rej_mode_o), .gain_o(gain_o)
);

// *** bench/adcc_host.sv ***
`timescale 1ns/1ps
module adcc_host (
  // clock and pins seen
  input  wire logic clk_i,
  input  wire logic sck_i,
  input  wire logic sdo_i,
  // pins driven
  output logic      cs_n_o    = 1'b1,
  output logic      sck_o     = 1'b0,
  output logic      sdi_o     = 1'b0,
  output logic      timeout_o = 1'b0
);
  task automatic wait_lvl(input logic v);
    int t;
    for (t = 0; t < 200 && sck_i !== v; t++) #10;
    if (t == 200) timeout_o = 1'b1;
  endtask

  // n = 0 only polls the status level
  task automatic xfer(input logic intl, input logic [15:0] cfg,
                      input int n, output logic [23:0] rd);
    int i;
    sck_o = intl;
    // first config bit must be settled before the first rising sck
    sdi_o = n > 0 ? cfg[15] : 1'b0;
    repeat (6) @(posedge clk_i);
    #1 cs_n_o = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rd = {23'h0, sdo_i};
    for (i = 0; i < n; i++) begin
      if (intl) begin
        wait_lvl(1'b1);
        rd = {rd[22:0], sdo_i};
        // after the last fall the line is back at our high level
        if (i < n - 1) wait_lvl(1'b0);
      end else begin
        #62.5 rd = {rd[22:0], sdo_i};
        sck_o = 1'b1;
        #62.5 sck_o = 1'b0;
      end
      sdi_o = i < 15 ? cfg[14 - i] : 1'b0;
    end
    repeat (6) @(posedge clk_i);
    #1 cs_n_o = 1'b1;
    // released line must not keep its last value
    sdi_o = ~sdi_o;
    sck_o = 1'b0;
  endtask
endmodule

// *** bench/adcc_ctrl_test.sv ***
`timescale 1ns/1ps
module adcc_ctrl_test;
  import adcc_pkg::*;
  localparam int TICKS = 20;
  logic        clk_i = 1'b0, resetn_i = 1'b0, osc = 1'b0, ext_osc = 1'b0;
  logic        over = 1'b0, under = 1'b0;
  logic [15:0] core = 16'h0000, cur = 16'h0000;
  logic [23:0] rd, exp_rd;
  logic [3:0]  pos, neg;
  logic [2:0]  gain;
  logic [1:0]  rej;
  logic        shared, temp, spd, mode, conv, start;
  logic        sck_d, sck_oe, sdo, sdo_oe;
  wire         cs_n, sck_h, sdi, hang;
  wire         sck_w = sck_oe ? sck_d : sck_h;
  wire         sdo_w = sdo_oe ? sdo : 1'bz;
  wire  [15:0] seen = {pos, shared ? 4'h0 : neg, shared, temp, rej, spd, gain};
  int          checks = 0, n_mismatch = 0, run = 0;

  initial forever #5 clk_i = ~clk_i;
  always #130 if (ext_osc) osc = ~osc;
  always @(posedge clk_i) run <= start ? 0 : run + 1;

  adcc_ctrl #(.CONV_TICKS(TICKS), .OSC_HALF(2), .ISCK_HALF(4)) dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .cs_n_i(cs_n),
    .sck_i(sck_w), .sck_o(sck_d), .sck_oe_o(sck_oe), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .conv_clock_pin_i(osc),
    .core_result_i(core), .core_over_i(over), .core_under_i(under),
    .conv_start_o(start), .converting_o(conv), .sleep_o(),
    .pos_sel_o(pos), .neg_sel_o(neg), .neg_is_shared_o(shared),
    .temp_sel_o(temp), .rej_mode_o(rej), .speed_2x_o(spd),
    .gain_o(gain), .sck_internal_o(mode));
  adcc_host host (.clk_i(clk_i), .sck_i(sck_w), .sdo_i(sdo_w),
    .cs_n_o(cs_n), .sck_o(sck_h), .sdi_o(sdi), .timeout_o(hang));

  task automatic check(input logic [23:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (hang === 1'b1) n_mismatch++;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [23:0] word(logic [15:0] d, logic o, u);
    return o ? CODE_OVER : u ? CODE_UNDER : {2'b00, ~d[15], d[15], d, 4'h0};
  endfunction

  function automatic logic [15:0] cfg_out(logic [15:0] c);
    return {c[3:0], c[4] ? 4'h0 : c[3:0] ^ 4'h1, c[4], c[5], c[7:6], c[8],
            c[11:9]};
  endfunction

  task automatic new_core;
    int r;
    r = $urandom % 4;
    core = 16'($urandom);
    over = r == 0;
    under = r == 1;
    exp_rd = word(core, over, under);
  endtask

  task automatic wait_conv;
    int n;
    for (n = 0; n < 400 && conv !== 1'b1; n++) #10;
    for (n = 0; n < 1000 && conv !== 1'b0; n++) #10;
    if (conv !== 1'b0 || n == 0) begin
      n_mismatch++;
      end_of_test;
    end
  endtask

  task automatic round(input logic intl, input logic [15:0] c, input int n);
    int e;
    logic in_time;
    host.xfer(intl, c, n, rd);
    if (n == 24) check(rd, exp_rd, "result");
    else check(24'(rd[7:0]), 24'(exp_rd[23:16]), "partial");
    check(24'(mode), 24'(intl), "sck mode");
    if (n >= 16) cur = c;
    new_core;
    wait_conv;
    e = (ext_osc ? 26 : 4) * TICKS;
    in_time = run * 10 >= e * 9 && run * 10 <= e * 11;
    check(24'(in_time), 24'h1, "time");
    check(24'(seen), 24'(cfg_out(cur)), "config");
    if (hang === 1'b1) end_of_test;
  endtask

  initial begin
    int i;
    void'($urandom(32'h80fd));
    new_core;
    repeat (12) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    @(posedge clk_i);
    #1 check(24'(seen), 24'(cfg_out(cur)), "reset config");
    host.xfer(1'b0, 16'h0000, 0, rd);
    check(24'(rd[0]), 24'h1, "busy flag");
    check(24'(mode), 24'h0, "power-up sck mode");
    wait_conv;
    host.xfer(1'b0, 16'h0000, 0, rd);
    check(24'(rd[0]), 24'(exp_rd[23]), "sleep poll");
    repeat (20) @(posedge clk_i);
    check(24'(conv), 24'h0, "no restart");
    // corners: all fields set, single-ended, abort, internal clock, ext osc
    for (i = 0; i < 12; i++) begin
      ext_osc = i == 11;
      round(i == 9, i == 0 ? 16'h0FFF : i == 1 ? 16'h0010 : 16'($urandom),
            i == 8 ? 8 : 24);
    end
    end_of_test;
  end
endmodule
